// File: logic/haptic_motor_sequencer.sv
`timescale 1ns/1ps
// Function
// - Six 8-bit registers, read and written by the host.
// - Reset loads 01h, 00h, 0Ah, 85h, 00h, 1Ah into the six registers.
// - A haptic sequence starts on a rising trigger request, or on its own while the loop bit is set.
// - Haptic drive phases use the overdrive voltage code.
// - Vibrate request drives forward continuously at the sustain voltage code.
// - Enable bit clear means standby; all requests are ignored.
// - Clock source bit picks internal oscillator or external clock pin.
// - Three divider bits cascade by 2, 4 and 16 for ratios 1 to 128.
// - Forward, coast and reverse last twice their code in ticks.
// - Recovery lasts four times its code in ticks.
// - New trigger edges are ignored until recovery has expired.
// - Over-temperature sets the latched control bit 3; host writes cannot change it.
// - Bridge legs, regulator enable and bypass are off while thermal or undervoltage fault is present.
// - Trigger and vibrate register bits are ORed with their pins.
// - Loop bit repeats the sequence continuously.
// - Timing codes sit in the low and high nibbles of two registers.
// - Voltage code 0 bypasses to supply; 1 is 5.0 V, down 0.1 V each.
// - Defaults give 1 ms tick, 20, 0, 10 and 32 ms phases.
// - Trigger overrides vibrate; vibrate drive resumes once the recovery phase begins.
// - External clock watchdog aborts the sequence after about 8 ms without edge.
// - Reset restores defaults and shuts down; host must pulse reset first.
module haptic_motor_sequencer #(
   parameter int unsigned OSC_CYCLES = haptic_pkg::OSC_TICK_CYCLES,
   parameter int unsigned WD_CYCLES = haptic_pkg::WATCHDOG_CYCLES
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register port
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Request and status pins
   input wire logic haptic_trigger,
   input wire logic vibrate_request,
   input wire logic ext_clock_pin,
   input wire logic over_temp,
   input wire logic under_voltage,
   // Bridge and regulator controls
   output logic bridge_forward,
   output logic bridge_reverse,
   output logic regulator_on,
   output logic regulator_bypass,
   output logic [4:0] regulator_code,
   output logic [5:0] regulator_target_dv
);

   typedef struct packed
   {
      logic [7:0] control_status;
      logic [7:0] clock_setup;
      logic [7:0] drive_coast_times;
      logic [7:0] reverse_holdoff_times;
      logic [7:0] overdrive_voltage;
      logic [7:0] sustain_voltage;
      logic [1:0] trig_sync;
      logic [1:0] vib_sync;
      logic [1:0] temp_sync;
      logic [1:0] uv_sync;
      logic trig_prev;
      haptic_pkg::phase_e phase;
      logic [5:0] cnt;
      logic [7:0] rdata;
      logic fwd;
      logic rev;
      logic reg_on;
      logic bypass;
      logic [4:0] code;
      logic [5:0] target;
   } seq_state_s;

   seq_state_s s;
   seq_state_s next_s;
   tick_if tk();

   logic enabled;
   logic loop_on;
   logic trig_req;
   logic trig_edge;
   logic vib_req;
   logic fault;
   logic haptic_run;
   logic vib_drive;
   logic [5:0] phase_len;
   logic [4:0] sel_code;

   // ----------------------------------------
   // Tick source
   // ----------------------------------------
   // Clock setup bits steer the divider directly
   assign tk.clock_source_select = s.clock_setup[haptic_pkg::CLK_SOURCE];
   assign tk.clock_halve = s.clock_setup[haptic_pkg::CLK_HALVE];
   assign tk.clock_quarter = s.clock_setup[haptic_pkg::CLK_QUARTER];
   assign tk.clock_sixteenth = s.clock_setup[haptic_pkg::CLK_SIXTEENTH];
   assign tk.standby = !enabled;

   tick_source #(
      .OSC_CYCLES(OSC_CYCLES),
      .WD_CYCLES(WD_CYCLES)
   ) u_tick (
      .clk(clk),
      .rst(rst),
      .ext_clock_pin(ext_clock_pin),
      .t(tk.timer)
   );

   // ----------------------------------------
   // Request decode
   // ----------------------------------------
   // Pins are read only from the second synchroniser stage
   assign enabled = s.control_status[haptic_pkg::CTRL_ENABLE];
   assign loop_on = s.control_status[haptic_pkg::CTRL_LOOP];
   assign trig_req = s.trig_sync[1] | s.control_status[haptic_pkg::CTRL_TRIGGER];
   assign vib_req = s.vib_sync[1] | s.control_status[haptic_pkg::CTRL_VIBRATE];
   assign trig_edge = trig_req & ~s.trig_prev;
   assign fault = s.temp_sync[1] | s.uv_sync[1];

   // Phase length in divided ticks
   always_comb
   begin
      case (s.phase)
         haptic_pkg::PH_FORWARD: phase_len = {1'b0, s.drive_coast_times[3:0], 1'b0};
         haptic_pkg::PH_COAST: phase_len = {1'b0, s.drive_coast_times[7:4], 1'b0};
         haptic_pkg::PH_REVERSE: phase_len = {1'b0, s.reverse_holdoff_times[3:0], 1'b0};
         haptic_pkg::PH_RECOVER: phase_len = {s.reverse_holdoff_times[7:4], 2'b00};
         default: phase_len = 6'h00;
      endcase
   end

   // Drive modes; recovery counts as finished drive so vibrate may resume
   assign haptic_run = (s.phase == haptic_pkg::PH_FORWARD) || (s.phase == haptic_pkg::PH_COAST)
      || (s.phase == haptic_pkg::PH_REVERSE);
   assign vib_drive = enabled && vib_req && !haptic_run;
   assign sel_code = haptic_run ? s.overdrive_voltage[4:0] : s.sustain_voltage[4:0];

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb
   begin
      next_s = s;
      next_s.trig_sync = {s.trig_sync[0], haptic_trigger};
      next_s.vib_sync = {s.vib_sync[0], vibrate_request};
      next_s.temp_sync = {s.temp_sync[0], over_temp};
      next_s.uv_sync = {s.uv_sync[0], under_voltage};
      next_s.trig_prev = trig_req;

      // Host writes; reserved bits are not stored and read as zero
      if (reg_write)
      begin
         case (reg_addr)
            haptic_pkg::ADDR_CONTROL:
            begin
               next_s.control_status = reg_wdata & haptic_pkg::MASK_CONTROL;
               next_s.control_status[haptic_pkg::CTRL_TEMP] =
                  s.control_status[haptic_pkg::CTRL_TEMP];
            end
            haptic_pkg::ADDR_CLOCK: next_s.clock_setup = reg_wdata & haptic_pkg::MASK_CLOCK;
            haptic_pkg::ADDR_DRIVE_COAST: next_s.drive_coast_times = reg_wdata;
            haptic_pkg::ADDR_REVERSE_HOLDOFF: next_s.reverse_holdoff_times = reg_wdata;
            haptic_pkg::ADDR_OVERDRIVE: next_s.overdrive_voltage = reg_wdata & haptic_pkg::MASK_VOLTAGE;
            haptic_pkg::ADDR_SUSTAIN: next_s.sustain_voltage = reg_wdata & haptic_pkg::MASK_VOLTAGE;
            default: next_s.rdata = s.rdata;
         endcase
      end
      // Latch wins over any write in the same cycle
      if (s.temp_sync[1])
      begin
         next_s.control_status[haptic_pkg::CTRL_TEMP] = 1'b1;
      end

      // Reads answer one cycle later; unmapped offsets give zero
      if (reg_read)
      begin
         case (reg_addr)
            haptic_pkg::ADDR_CONTROL: next_s.rdata = s.control_status;
            haptic_pkg::ADDR_CLOCK: next_s.rdata = s.clock_setup;
            haptic_pkg::ADDR_DRIVE_COAST: next_s.rdata = s.drive_coast_times;
            haptic_pkg::ADDR_REVERSE_HOLDOFF: next_s.rdata = s.reverse_holdoff_times;
            haptic_pkg::ADDR_OVERDRIVE: next_s.rdata = s.overdrive_voltage;
            haptic_pkg::ADDR_SUSTAIN: next_s.rdata = s.sustain_voltage;
            default: next_s.rdata = 8'h00;
         endcase
      end

      // Sequencer
      if (!enabled)
      begin
         next_s.phase = haptic_pkg::PH_IDLE;
         next_s.cnt = 6'h00;
      end
      else if (tk.watchdog_abort && s.phase != haptic_pkg::PH_IDLE)
      begin
         next_s.phase = haptic_pkg::PH_IDLE;
         next_s.cnt = 6'h00;
      end
      else
      begin
         case (s.phase)
            haptic_pkg::PH_IDLE:
            begin
               // Trigger edge overrides vibrate; loop mode starts on its own
               if (trig_edge || loop_on)
               begin
                  next_s.phase = haptic_pkg::PH_FORWARD;
                  next_s.cnt = 6'h00;
               end
            end
            haptic_pkg::PH_FORWARD, haptic_pkg::PH_COAST, haptic_pkg::PH_REVERSE,
            haptic_pkg::PH_RECOVER:
            begin
               // Edges seen here are dropped, including during recovery
               if (s.cnt >= phase_len)
               begin
                  next_s.cnt = 6'h00;
                  case (s.phase)
                     haptic_pkg::PH_FORWARD: next_s.phase = haptic_pkg::PH_COAST;
                     haptic_pkg::PH_COAST: next_s.phase = haptic_pkg::PH_REVERSE;
                     haptic_pkg::PH_REVERSE: next_s.phase = haptic_pkg::PH_RECOVER;
                     default: next_s.phase = loop_on ? haptic_pkg::PH_FORWARD
                        : haptic_pkg::PH_IDLE;
                  endcase
               end
               else if (tk.tick)
               begin
                  next_s.cnt = s.cnt + 6'h01;
               end
            end
            default:
            begin
               next_s.phase = haptic_pkg::PH_IDLE;
               next_s.cnt = 6'h00;
            end
         endcase
      end

      // Registered outputs; coast leaves both legs undriven
      next_s.fwd = !fault && ((s.phase == haptic_pkg::PH_FORWARD) || vib_drive);
      next_s.rev = !fault && (s.phase == haptic_pkg::PH_REVERSE);
      next_s.reg_on = !fault && (haptic_run || vib_drive);
      next_s.code = sel_code;
      next_s.bypass = !fault && (haptic_run || vib_drive) && (sel_code == 5'h00);
      next_s.target = (sel_code == 5'h00) ? 6'h00 : (haptic_pkg::VOLT_BASE_DV - {1'b0, sel_code});
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   // Reset stands for the active low reset pin; no power-on reset exists
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s <= '0;
         s.control_status <= haptic_pkg::RST_CONTROL;
         s.clock_setup <= haptic_pkg::RST_CLOCK;
         s.drive_coast_times <= haptic_pkg::RST_DRIVE_COAST;
         s.reverse_holdoff_times <= haptic_pkg::RST_REVERSE_HOLDOFF;
         s.overdrive_voltage <= haptic_pkg::RST_OVERDRIVE;
         s.sustain_voltage <= haptic_pkg::RST_SUSTAIN;
         s.phase <= haptic_pkg::PH_IDLE;
      end
      else
      begin
         s <= next_s;
      end
   end

   // Outputs
   assign reg_rdata = s.rdata;
   assign bridge_forward = s.fwd;
   assign bridge_reverse = s.rev;
   assign regulator_on = s.reg_on;
   assign regulator_bypass = s.bypass;
   assign regulator_code = s.code;
   assign regulator_target_dv = s.target;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_defaults;
      @(posedge clk) rst |=> (s.control_status == 8'h01 && s.drive_coast_times == 8'h0a
         && s.reverse_holdoff_times == 8'h85 && s.sustain_voltage == 8'h1a);
   endproperty
   a_defaults: assert property (p_defaults) else $error("reset defaults wrong");

   property p_level_no_start;
      @(posedge clk) disable iff (rst)
      (s.phase == haptic_pkg::PH_IDLE && !trig_edge && !loop_on) |=> s.phase == haptic_pkg::PH_IDLE;
   endproperty
   a_level_no_start: assert property (p_level_no_start) else $error("start without edge");

   property p_overdrive;
      @(posedge clk) disable iff (rst)
      (haptic_run && !fault) |=> (regulator_on && regulator_code == $past(s.overdrive_voltage[4:0]));
   endproperty
   a_overdrive: assert property (p_overdrive) else $error("wrong haptic voltage");

   property p_vibrate;
      @(posedge clk) disable iff (rst)
      (enabled && vib_req && s.phase == haptic_pkg::PH_IDLE && !fault)
      |=> (bridge_forward && !bridge_reverse && regulator_code == $past(s.sustain_voltage[4:0]));
   endproperty
   a_vibrate: assert property (p_vibrate) else $error("vibrate drive missing");

   property p_standby;
      @(posedge clk) disable iff (rst)
      !enabled |=> (s.phase == haptic_pkg::PH_IDLE && s.cnt == 6'h00);
   endproperty
   a_standby: assert property (p_standby) else $error("active in standby");

   property p_recovery_hold;
      @(posedge clk) disable iff (rst)
      (s.phase == haptic_pkg::PH_RECOVER && s.cnt < phase_len && enabled && !tk.watchdog_abort)
      |=> s.phase == haptic_pkg::PH_RECOVER;
   endproperty
   a_recovery_hold: assert property (p_recovery_hold) else $error("recovery cut short");

   property p_temp_latch;
      @(posedge clk) disable iff (rst)
      (s.temp_sync[1] || s.control_status[haptic_pkg::CTRL_TEMP])
      |=> s.control_status[haptic_pkg::CTRL_TEMP] [*2];
   endproperty
   a_temp_latch: assert property (p_temp_latch) else $error("temp latch lost");

   property p_fault_off;
      @(posedge clk) disable iff (rst)
      fault |=> (!bridge_forward && !bridge_reverse && !regulator_on);
   endproperty
   a_fault_off: assert property (p_fault_off) else $error("drive during fault");

   property p_zero_coast;
      @(posedge clk) disable iff (rst)
      (s.phase == haptic_pkg::PH_COAST && s.drive_coast_times[7:4] == 4'h0 && enabled
         && !tk.watchdog_abort) |=> s.phase == haptic_pkg::PH_REVERSE;
   endproperty
   a_zero_coast: assert property (p_zero_coast) else $error("zero coast not skipped");

   property p_count_on_tick;
      @(posedge clk) disable iff (rst)
      (s.phase != haptic_pkg::PH_IDLE && !tk.tick && enabled && s.cnt < phase_len
         && !tk.watchdog_abort) |=> $stable(s.cnt);
   endproperty
   a_count_on_tick: assert property (p_count_on_tick) else $error("count without tick");
endmodule

// File: logic/haptic_pkg.sv
package haptic_pkg;

   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [7:0] ADDR_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_CLOCK = 8'h01;
   localparam logic [7:0] ADDR_DRIVE_COAST = 8'h02;
   localparam logic [7:0] ADDR_REVERSE_HOLDOFF = 8'h03;
   localparam logic [7:0] ADDR_OVERDRIVE = 8'h04;
   localparam logic [7:0] ADDR_SUSTAIN = 8'h05;

   // ----------------------------------------
   // Reset values and writable masks
   // ----------------------------------------
   localparam logic [7:0] RST_CONTROL = 8'h01;
   localparam logic [7:0] RST_CLOCK = 8'h00;
   localparam logic [7:0] RST_DRIVE_COAST = 8'h0a;
   localparam logic [7:0] RST_REVERSE_HOLDOFF = 8'h85;
   localparam logic [7:0] RST_OVERDRIVE = 8'h00;
   localparam logic [7:0] RST_SUSTAIN = 8'h1a;
   localparam logic [7:0] MASK_CONTROL = 8'h1f;
   localparam logic [7:0] MASK_CLOCK = 8'h0f;
   localparam logic [7:0] MASK_VOLTAGE = 8'h1f;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int CTRL_ENABLE = 0;
   localparam int CTRL_TRIGGER = 1;
   localparam int CTRL_VIBRATE = 2;
   localparam int CTRL_TEMP = 3;
   localparam int CTRL_LOOP = 4;
   localparam int CLK_SOURCE = 0;
   localparam int CLK_HALVE = 1;
   localparam int CLK_QUARTER = 2;
   localparam int CLK_SIXTEENTH = 3;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int unsigned CLK_HZ = 25_000_000;
   localparam int unsigned OSC_TICK_MS = 1;
   localparam int unsigned WATCHDOG_MS = 8;
   localparam int unsigned OSC_TICK_CYCLES = CLK_HZ / 1000 * OSC_TICK_MS;
   localparam int unsigned WATCHDOG_CYCLES = CLK_HZ / 1000 * WATCHDOG_MS;

   // Code 1 means 5.0 V, so the base is one step above it, in 0.1 V units
   localparam logic [5:0] VOLT_BASE_DV = 6'h33;

   // ----------------------------------------
   // Sequence phases
   // ----------------------------------------
   typedef enum logic [2:0]
   {
      PH_IDLE = 3'b000,
      PH_FORWARD = 3'b001,
      PH_COAST = 3'b010,
      PH_REVERSE = 3'b011,
      PH_RECOVER = 3'b100
   } phase_e;

endpackage

// File: logic/tick_if.sv
`timescale 1ns/1ps
interface tick_if;
   // Clock setup from the sequencer
   logic clock_source_select;
   logic clock_halve;
   logic clock_quarter;
   logic clock_sixteenth;
   logic standby;
   // Results from the tick source
   logic tick;
   logic watchdog_abort;

   modport seq
   (
      output clock_source_select, clock_halve, clock_quarter, clock_sixteenth, standby,
      input tick, watchdog_abort
   );
   modport timer
   (
      input clock_source_select, clock_halve, clock_quarter, clock_sixteenth, standby,
      output tick, watchdog_abort
   );
endinterface

// File: logic/tick_source.sv
`timescale 1ns/1ps
module tick_source #(
   parameter int unsigned OSC_CYCLES = haptic_pkg::OSC_TICK_CYCLES,
   parameter int unsigned WD_CYCLES = haptic_pkg::WATCHDOG_CYCLES
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // External timer clock pin
   input wire logic ext_clock_pin,
   // Sequencer side
   tick_if.timer t
);
   localparam int OW = $clog2(OSC_CYCLES + 1);
   localparam int WW = $clog2(WD_CYCLES + 1);

   typedef struct packed
   {
      logic [2:0] ext_sync;
      logic [OW-1:0] osc_cnt;
      logic [WW-1:0] wd_cnt;
      logic [7:0] div_cnt;
      logic tick;
      logic wd_abort;
   } tick_state_s;

   tick_state_s s;
   tick_state_s next_s;
   logic ext_edge;
   logic base_tick;
   logic [7:0] div_last;

   // ----------------------------------------
   // Base tick and divider
   // ----------------------------------------
   // Stage 2 against its delayed copy, stage 1 is left to settle
   assign ext_edge = s.ext_sync[1] & ~s.ext_sync[2];
   assign div_last = (8'h01 << {t.clock_sixteenth, t.clock_quarter, t.clock_halve}) - 8'h01;
   assign base_tick = t.clock_source_select ? ext_edge : (s.osc_cnt == OW'(OSC_CYCLES - 1));

   always_comb
   begin
      next_s = s;
      next_s.ext_sync = {s.ext_sync[1:0], ext_clock_pin};
      next_s.tick = 1'b0;
      // Internal oscillator, 1 ms per tick at the default count
      if (t.standby || s.osc_cnt == OW'(OSC_CYCLES - 1))
      begin
         next_s.osc_cnt = '0;
      end
      else
      begin
         next_s.osc_cnt = s.osc_cnt + 1'b1;
      end
      // Watchdog restarts on each rising pin edge and saturates at the limit
      if (!t.clock_source_select || ext_edge)
      begin
         next_s.wd_cnt = '0;
      end
      else if (s.wd_cnt != WW'(WD_CYCLES))
      begin
         next_s.wd_cnt = s.wd_cnt + 1'b1;
      end
      next_s.wd_abort = t.clock_source_select && (next_s.wd_cnt == WW'(WD_CYCLES));
      // Cascaded divide, ratio 1 to 128
      if (t.standby)
      begin
         next_s.div_cnt = 8'h00;
      end
      else if (base_tick)
      begin
         if (s.div_cnt >= div_last)
         begin
            next_s.div_cnt = 8'h00;
            next_s.tick = 1'b1;
         end
         else
         begin
            next_s.div_cnt = s.div_cnt + 8'h01;
         end
      end
   end

   // Register the state
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s <= '0;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign t.tick = s.tick;
   assign t.watchdog_abort = s.wd_abort;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_tick_ratio;
      @(posedge clk) disable iff (rst)
      (t.tick && !t.standby && div_last == 8'h00 && !$past(t.clock_source_select))
      |-> $past(s.osc_cnt) == OW'(OSC_CYCLES - 1);
   endproperty
   a_tick_ratio: assert property (p_tick_ratio) else $error("tick without base tick");

   property p_wd_edge_clears;
      @(posedge clk) disable iff (rst)
      (t.clock_source_select && ext_edge) |=> !t.watchdog_abort;
   endproperty
   a_wd_edge_clears: assert property (p_wd_edge_clears) else $error("watchdog on live clock");
endmodule

// File: bench/host_model.sv
`timescale 1ns/1ps
module host_model
(
   // Clock
   input wire logic clk,
   // Reset and register port
   output logic rst,
   output logic reg_write,
   output logic reg_read,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata
);
   // -----------------------
   // Host side of the block
   // -----------------------
   // No power-on reset inside, so the host pulses it first
   initial
   begin
      reg_write = 1'b0;
      reg_read = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      pulse_reset();
   end
   // Reset held three cycles, released just after an edge
   task automatic pulse_reset();
      rst = 1'b1;
      repeat (3) @(posedge clk);
      #1 rst = 1'b0;
   endtask
   // One-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1 {reg_write, reg_addr, reg_wdata} = {1'b1, a, d};
      @(posedge clk);
      #1 reg_write = 1'b0;
   endtask
   // Read data lands at the edge after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      #1 {reg_read, reg_addr} = {1'b1, a};
      @(posedge clk);
      #1 reg_read = 1'b0;
      d = reg_rdata;
   endtask
endmodule

// File: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic clk = 1'b0;
   logic rst, reg_write, reg_read;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic haptic_trigger = 1'b0;
   logic vibrate_request = 1'b0;
   logic ext_clock_pin = 1'b0;
   logic over_temp = 1'b0;
   logic under_voltage = 1'b0;
   logic bridge_forward, bridge_reverse, regulator_on, regulator_bypass;
   logic [4:0] regulator_code;
   logic [5:0] regulator_target_dv;
   int err_total = 0;
   int check_count = 0;
   bit ext_run = 1'b0;
   logic [7:0] dflt [7] = '{8'h01, 8'h00, 8'h0a, 8'h85, 8'h00, 8'h1a, 8'h00};

   // Short oscillator tick keeps the run brief
   always #20 clk = ~clk;
   haptic_motor_sequencer #(.OSC_CYCLES(10), .WD_CYCLES(200)) i_dut
   (
      .clk, .rst, .reg_write, .reg_read, .reg_addr, .reg_wdata, .reg_rdata,
      .haptic_trigger, .vibrate_request, .ext_clock_pin, .over_temp,
      .under_voltage, .bridge_forward, .bridge_reverse, .regulator_on,
      .regulator_bypass, .regulator_code, .regulator_target_dv
   );
   host_model i_host
   (
      .clk, .rst, .reg_write, .reg_read, .reg_addr, .reg_wdata, .reg_rdata
   );

   // External timer clock, ten system clocks a period while running
   always
   begin
      step(5);
      if (ext_run)
         ext_clock_pin = ~ext_clock_pin;
   end

   // -----------------------
   // Helpers
   // -----------------------
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e)
      begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      i_host.rd(a, d);
      chk("register", e, d);
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Start one sequence, count drive cycles over a window longer than it
   task automatic seq(input bit pin, input int lo, input int hi);
      int f, r, bad;
      f = 0;
      r = 0;
      bad = 0;
      if (pin)
         haptic_trigger = 1'b1;
      else
      begin
         i_host.wr(8'h00, 8'h03);
         i_host.wr(8'h00, 8'h01);
      end
      repeat (600)
      begin
         @(posedge clk);
         #1;
         f += bridge_forward;
         r += bridge_reverse;
         if (bridge_reverse && f == 0)
            bad++;
         if (bridge_forward && {regulator_code, regulator_target_dv} !== 11'h16e)
            bad++;
      end
      chk("forward length", 8'h01, {7'h0, f >= lo && f <= hi});
      chk("reverse length", 8'h01, {7'h0, r >= lo && r <= hi});
      chk("phase order", 8'h00, bad[7:0]);
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // -----------------------
   // Tests
   // -----------------------
   // Watchdog against a hang
   initial
   begin
      #800000;
      err_total++;
      finish_test();
   end
   initial
   begin
      wait (rst === 1'b0);
      step(3);
      for (int i = 0; i < 7; i++)
         rchk(i[7:0], dflt[i]);
      i_host.wr(8'h01, 8'hff);
      rchk(8'h01, 8'h0f);
      i_host.wr(8'h05, 8'hff);
      rchk(8'h05, 8'h1f);
      i_host.wr(8'h05, 8'h1a);
      i_host.wr(8'h01, 8'h00);
      // Short codes: forward 1, coast 0, reverse 1, recovery 1
      i_host.wr(8'h02, 8'h01);
      i_host.wr(8'h03, 8'h11);
      i_host.wr(8'h04, 8'h05);
      seq(1'b0, 10, 22);
      // Pin held high afterwards must not start a second run
      seq(1'b1, 10, 22);
      haptic_trigger = 1'b0;
      i_host.wr(8'h01, 8'h02);
      seq(1'b0, 20, 44);
      i_host.wr(8'h01, 8'h00);
      // Loop mode repeats without further edges
      i_host.wr(8'h00, 8'h11);
      seq(1'b1, 40, 600);
      haptic_trigger = 1'b0;
      i_host.wr(8'h00, 8'h01);
      // Ticks from the external pin, then with that pin stopped
      ext_run = 1'b1;
      i_host.wr(8'h01, 8'h01);
      step(100);
      seq(1'b0, 10, 22);
      ext_run = 1'b0;
      step(250);
      seq(1'b0, 0, 2);
      i_host.wr(8'h01, 8'h00);
      vibrate_request = 1'b1;
      step(8);
      chk("vibrate drive", 8'h01, {7'h0, bridge_forward});
      chk("vibrate code", 8'h1a, {3'h0, regulator_code});
      chk("vibrate target", 8'h19, {2'h0, regulator_target_dv});
      chk("vibrate regulator", 8'h01, {7'h0, regulator_on});
      // Trigger during vibrate runs the sequence first
      i_host.wr(8'h00, 8'h03);
      step(3);
      chk("override code", 8'h05, {3'h0, regulator_code});
      i_host.wr(8'h00, 8'h01);
      step(150);
      chk("resumed code", 8'h1a, {3'h0, regulator_code});
      i_host.wr(8'h05, 8'h00);
      step(2);
      chk("bypass", 8'h01, {7'h0, regulator_bypass});
      chk("bypass target", 8'h00, {2'h0, regulator_target_dv});
      i_host.wr(8'h05, 8'h1a);
      under_voltage = 1'b1;
      step(6);
      chk("drive in fault", 8'h00, {7'h0, bridge_forward});
      chk("regulator in fault", 8'h00, {7'h0, regulator_on});
      under_voltage = 1'b0;
      step(6);
      chk("drive after fault", 8'h01, {7'h0, bridge_forward});
      i_host.wr(8'h00, 8'h00);
      step(4);
      chk("standby drive", 8'h00, {7'h0, bridge_forward});
      vibrate_request = 1'b0;
      over_temp = 1'b1;
      step(6);
      over_temp = 1'b0;
      step(6);
      rchk(8'h00, 8'h08);
      i_host.wr(8'h00, 8'h01);
      rchk(8'h00, 8'h09);
      i_host.pulse_reset();
      step(3);
      rchk(8'h00, 8'h01);
      finish_test();
   end
endmodule
